// ---- verilog/msf_params.svh ----
`ifndef MSF_PARAMS_SVH
`define MSF_PARAMS_SVH

`define MSF_CLK_MHZ         125
`define MSF_OP_CYCLE_US     888
`define MSF_MAIN_CYCLE_US   3552
`define MSF_DATA_W          32
`define MSF_ADDR_W          4
`define MSF_AXIS_W          3
`define MSF_BANK_W          2
`define MSF_MEM_AW          5
`define MSF_MEM_DEPTH       32
`define MSF_LAST_AXIS       3'h7
`define MSF_FIRST_AXIS      3'h0
`define MSF_AXIS_STEP       3'h1

`define MSF_REG_FLAGS       4'h0
`define MSF_REG_CTRL        4'h1
`define MSF_REG_RSTOP       4'h2
`define MSF_REG_INT_STAT    4'h3
`define MSF_REG_INT_MASK    4'h4

`define MSF_FLAG_READY      0
`define MSF_FLAG_TEST_ON    1
`define MSF_FLAG_FS_IN      2
`define MSF_FLAG_SCOPE      3
`define MSF_FLAG_FS_LATCH   4
`define MSF_FLAG_TEST_ERR   5
`define MSF_FLAG_OVERSPEED  6
`define MSF_FLAG_WALK_BUSY  7

`define MSF_CTRL_SERVO_ON   0
`define MSF_CTRL_VARIANT_NEW 1
`define MSF_CTRL_W          2
`define MSF_CTRL_RST        2'h0

`define MSF_RSTOP_W         16
`define MSF_RSTOP_RST       16'h0000
`define MSF_RSTOP_ONE       16'h0001

`define MSF_EV_READY        0
`define MSF_EV_FS           1
`define MSF_EV_TEST_ERR     2
`define MSF_EV_RESTORE      3
`define MSF_EV_OVERSPEED    4
`define MSF_EV_W            5
`define MSF_EV_RST          5'h00

`define MSF_BANK_FEED       2'h0
`define MSF_BANK_REAL       2'h1
`define MSF_BANK_SNAP       2'h2

`endif

// ---- verilog/msf_pkg.sv ----
package msf_pkg;

  typedef enum logic [1:0] {
    RDY_IDLE  = 2'b00,
    RDY_CHECK = 2'b01,
    RDY_XFER  = 2'b11,
    RDY_ON    = 2'b10
  } msf_rdy_state_t;

  typedef enum logic [1:0] {
    W_IDLE  = 2'b00,
    W_READ  = 2'b01,
    W_WRITE = 2'b11
  } msf_walk_state_t;

  typedef enum logic [1:0] {
    WM_REAL    = 2'b00,
    WM_SNAP    = 2'b01,
    WM_RESTORE = 2'b11
  } msf_walk_mode_t;

endpackage : msf_pkg

// ---- verilog/msf_tick_gen.sv ----
`timescale 1ns/10ps
module msf_tick_gen import msf_pkg::*; #(
  parameter int unsigned PERIOD = 2
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // One-cycle pulse once per period.
  output logic      tick_r
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        tick_nxt;

  always_comb begin
    tick_nxt = (cnt_r == PERIOD - 32'h1);
    cnt_nxt  = tick_nxt ? 32'h0 : cnt_r + 32'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

endmodule : msf_tick_gen

// ---- verilog/msf_axis_mem.sv ----
`timescale 1ns/10ps
`include "msf_params.svh"
module msf_axis_mem import msf_pkg::*; (
  // Clock.
  input  wire logic                   clk,
  // Write port.
  input  wire logic                   we,
  input  wire logic [`MSF_MEM_AW-1:0] waddr,
  input  wire logic [`MSF_DATA_W-1:0] wdata,
  // Registered read port.
  input  wire logic                   re,
  input  wire logic [`MSF_MEM_AW-1:0] raddr,
  output logic      [`MSF_DATA_W-1:0] rdata_r
);

  logic [`MSF_DATA_W-1:0] mem [`MSF_MEM_DEPTH];

  // No reset: a restore only ever reads words that a snapshot wrote first.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata_r <= mem[raddr];
    end
  end

endmodule : msf_axis_mem

// ---- verilog/msf_top.sv ----
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "msf_params.svh"
module msf_top import msf_pkg::*; #(
  parameter int unsigned OP_CYCLE_CYC   = `MSF_OP_CYCLE_US * `MSF_CLK_MHZ,
  parameter int unsigned MAIN_CYCLE_CYC = `MSF_MAIN_CYCLE_US * `MSF_CLK_MHZ
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Register port.
  input  wire logic [`MSF_ADDR_W-1:0]  reg_addr,
  input  wire logic [`MSF_DATA_W-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`MSF_DATA_W-1:0]  reg_rdata,
  // Sequence side.
  input  wire logic                    plc_ready_request,
  input  wire logic                    param_check_error,
  input  wire logic                    test_mode_request,
  input  wire logic                    test_mode_allowed,
  input  wire logic                    test_mode_active,
  input  wire logic                    scope_active,
  input  wire logic                    forced_stop_input,
  input  wire logic                    positioning_active,
  // Axis value writes from the motion engine.
  input  wire logic                    axis_wr,
  input  wire logic                    axis_wr_real,
  input  wire logic [`MSF_AXIS_W-1:0]  axis_wr_idx,
  input  wire logic [`MSF_DATA_W-1:0]  axis_wr_value,
  output logic                         axis_wr_ready,
  // Flags.
  output logic                         processor_ready_flag,
  output logic                         test_mode_on_flag,
  output logic                         forced_stop_input_flag,
  output logic                         scope_executing_flag,
  output logic                         forced_stop_latch_flag,
  output logic                         test_request_error_flag,
  output logic                         overspeed_error_flag,
  // Amplifier side.
  output logic                         servo_param_xfer,
  output logic                         mcode_clear,
  output logic                         all_axes_servo_on_cmd,
  // Interrupt.
  output logic                         irq
);

  function automatic logic reg_hit(input logic [`MSF_ADDR_W-1:0] a,
                                   input logic [`MSF_ADDR_W-1:0] idx);
    reg_hit = (a == idx);
  endfunction : reg_hit

  logic op_tick;
  logic main_tick;

  msf_tick_gen #(.PERIOD(OP_CYCLE_CYC)) u_op_tick (
    .clk    (clk),
    .rst_n  (rst_n),
    .tick_r (op_tick)
  );

  msf_tick_gen #(.PERIOD(MAIN_CYCLE_CYC)) u_main_tick (
    .clk    (clk),
    .rst_n  (rst_n),
    .tick_r (main_tick)
  );

  // Ready sequence state.
  msf_rdy_state_t rdy_r, rdy_nxt;
  logic plc_q_r, ready_nxt, xfer_nxt;

  always_comb begin
    rdy_nxt = rdy_r;
    unique case (rdy_r)
      RDY_IDLE: begin
        if (plc_ready_request && !plc_q_r) rdy_nxt = RDY_CHECK;
      end
      RDY_CHECK: begin
        if (!plc_ready_request || param_check_error) rdy_nxt = RDY_IDLE;
        else rdy_nxt = RDY_XFER;
      end
      RDY_XFER: begin
        rdy_nxt = plc_ready_request ? RDY_ON : RDY_IDLE;
      end
      RDY_ON: begin
        if (!plc_ready_request) rdy_nxt = RDY_IDLE;
      end
    endcase
    ready_nxt = (rdy_nxt == RDY_ON);
    xfer_nxt  = (rdy_nxt == RDY_XFER);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_r                <= RDY_IDLE;
      plc_q_r              <= 1'b0;
      processor_ready_flag <= 1'b0;
      servo_param_xfer     <= 1'b0;
      mcode_clear          <= 1'b0;
    end else begin
      rdy_r                <= rdy_nxt;
      plc_q_r              <= plc_ready_request;
      processor_ready_flag <= ready_nxt;
      servo_param_xfer     <= xfer_nxt;
      mcode_clear          <= xfer_nxt;
    end
  end

  // Software registers and flags.
  logic [`MSF_CTRL_W-1:0]  ctrl_r, ctrl_nxt;
  logic [`MSF_RSTOP_W-1:0] rstop_time_r, rstop_time_nxt;
  logic [`MSF_RSTOP_W-1:0] rstop_cnt_r, rstop_cnt_nxt;
  logic [`MSF_EV_W-1:0]    int_stat_r, int_stat_nxt, int_mask_r, int_mask_nxt, ev;
  logic [`MSF_DATA_W-1:0]  rdata_nxt;
  logic fs_nxt, latch_nxt, test_on_nxt, scope_nxt, terr_nxt, ovs_nxt, servo_nxt, irq_nxt;
  logic flags_wr, stat_wr, fs_rise, fs_fall, rstop_expire, variant_new;
  msf_walk_state_t walk_r, walk_nxt;
  msf_walk_mode_t  wmode_r, wmode_nxt;
  logic [`MSF_AXIS_W-1:0] waxis_r, waxis_nxt;
  logic walk_done;

  assign variant_new = ctrl_r[`MSF_CTRL_VARIANT_NEW];

  always_comb begin
    flags_wr  = reg_wr && reg_hit(reg_addr, `MSF_REG_FLAGS);
    stat_wr   = reg_wr && reg_hit(reg_addr, `MSF_REG_INT_STAT);
    fs_nxt    = op_tick ? forced_stop_input : forced_stop_input_flag;
    fs_rise   = fs_nxt && !forced_stop_input_flag;
    fs_fall   = !fs_nxt && forced_stop_input_flag;
    // Set wins over the clearing write.
    latch_nxt = fs_nxt || (forced_stop_latch_flag &&
                !(flags_wr && reg_wdata[`MSF_FLAG_FS_LATCH]));
    test_on_nxt = main_tick ? test_mode_active : test_mode_on_flag;
    scope_nxt   = main_tick ? scope_active : scope_executing_flag;
    terr_nxt  = (test_mode_request && !test_mode_allowed) ||
                (test_request_error_flag && !(flags_wr && reg_wdata[`MSF_FLAG_TEST_ERR]));
    rstop_expire = op_tick && (rstop_cnt_r == `MSF_RSTOP_ONE);
    ovs_nxt   = (fs_fall && rstop_cnt_r != `MSF_RSTOP_RST) ||
                (overspeed_error_flag && !(flags_wr && reg_wdata[`MSF_FLAG_OVERSPEED]));
    // The decelerating count runs on operation ticks so the figure matches the parameter block.
    rstop_cnt_nxt = rstop_cnt_r;
    if (fs_rise && positioning_active && !variant_new) rstop_cnt_nxt = rstop_time_r;
    else if (op_tick && rstop_cnt_r != `MSF_RSTOP_RST) rstop_cnt_nxt = rstop_cnt_r - `MSF_RSTOP_ONE;
    servo_nxt = ctrl_r[`MSF_CTRL_SERVO_ON] && !(fs_nxt && !variant_new);
    ctrl_nxt  = (reg_wr && reg_hit(reg_addr, `MSF_REG_CTRL)) ?
                reg_wdata[`MSF_CTRL_W-1:0] : ctrl_r;
    rstop_time_nxt = (reg_wr && reg_hit(reg_addr, `MSF_REG_RSTOP)) ?
                     reg_wdata[`MSF_RSTOP_W-1:0] : rstop_time_r;
    int_mask_nxt = (reg_wr && reg_hit(reg_addr, `MSF_REG_INT_MASK)) ?
                   reg_wdata[`MSF_EV_W-1:0] : int_mask_r;
    ev = '0;
    ev[`MSF_EV_READY]     = ready_nxt && !processor_ready_flag;
    ev[`MSF_EV_FS]        = fs_rise;
    ev[`MSF_EV_TEST_ERR]  = terr_nxt && !test_request_error_flag;
    ev[`MSF_EV_RESTORE]   = walk_done && (wmode_r == WM_RESTORE);
    ev[`MSF_EV_OVERSPEED] = ovs_nxt && !overspeed_error_flag;
    irq_nxt = |(int_stat_nxt & int_mask_nxt);
    rdata_nxt = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `MSF_REG_FLAGS: begin
          rdata_nxt[`MSF_FLAG_READY]     = processor_ready_flag;
          rdata_nxt[`MSF_FLAG_TEST_ON]   = test_mode_on_flag;
          rdata_nxt[`MSF_FLAG_FS_IN]     = forced_stop_input_flag;
          rdata_nxt[`MSF_FLAG_SCOPE]     = scope_executing_flag;
          rdata_nxt[`MSF_FLAG_FS_LATCH]  = forced_stop_latch_flag;
          rdata_nxt[`MSF_FLAG_TEST_ERR]  = test_request_error_flag;
          rdata_nxt[`MSF_FLAG_OVERSPEED] = overspeed_error_flag;
          rdata_nxt[`MSF_FLAG_WALK_BUSY] = (walk_r != W_IDLE);
        end
        `MSF_REG_CTRL:     rdata_nxt[`MSF_CTRL_W-1:0]  = ctrl_r;
        `MSF_REG_RSTOP:    rdata_nxt[`MSF_RSTOP_W-1:0] = rstop_time_r;
        `MSF_REG_INT_STAT: rdata_nxt[`MSF_EV_W-1:0]    = int_stat_r;
        `MSF_REG_INT_MASK: rdata_nxt[`MSF_EV_W-1:0]    = int_mask_r;
        default:           rdata_nxt = '0;
      endcase
    end
  end

  // Each status bit is sticky; an event in the clearing cycle keeps it set.
  for (genvar i = 0; i < `MSF_EV_W; i++) begin : g_stat
    assign int_stat_nxt[i] = ev[i] || (int_stat_r[i] && !(stat_wr && reg_wdata[i]));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      forced_stop_input_flag  <= 1'b0;
      forced_stop_latch_flag  <= 1'b0;
      test_mode_on_flag       <= 1'b0;
      scope_executing_flag    <= 1'b0;
      test_request_error_flag <= 1'b0;
      overspeed_error_flag    <= 1'b0;
      all_axes_servo_on_cmd   <= 1'b0;
      rstop_cnt_r             <= `MSF_RSTOP_RST;
      rstop_time_r            <= `MSF_RSTOP_RST;
      ctrl_r                  <= `MSF_CTRL_RST;
      int_stat_r              <= `MSF_EV_RST;
      int_mask_r              <= `MSF_EV_RST;
      irq                     <= 1'b0;
      reg_rdata               <= '0;
    end else begin
      forced_stop_input_flag  <= fs_nxt;
      forced_stop_latch_flag  <= latch_nxt;
      test_mode_on_flag       <= test_on_nxt;
      scope_executing_flag    <= scope_nxt;
      test_request_error_flag <= terr_nxt;
      overspeed_error_flag    <= ovs_nxt;
      all_axes_servo_on_cmd   <= servo_nxt;
      rstop_cnt_r             <= rstop_cnt_nxt;
      rstop_time_r            <= rstop_time_nxt;
      ctrl_r                  <= ctrl_nxt;
      int_stat_r              <= int_stat_nxt;
      int_mask_r              <= int_mask_nxt;
      irq                     <= irq_nxt;
      reg_rdata               <= rdata_nxt;
    end
  end

  // Axis walk: copies one bank into another, one axis per two cycles.
  logic mem_we, mem_re, eng_take, axis_ready_nxt, restore_pend_r, restore_pend_nxt;
  logic [`MSF_MEM_AW-1:0] mem_waddr, mem_raddr;
  logic [`MSF_DATA_W-1:0] mem_wdata, mem_rdata;
  logic [`MSF_BANK_W-1:0] src_bank, dst_bank;

  always_comb begin
    walk_nxt  = walk_r;
    wmode_nxt = wmode_r;
    waxis_nxt = waxis_r;
    walk_done = 1'b0;
    // A restore falling due while a walk runs, or beside a new stop, waits rather than drops.
    restore_pend_nxt = restore_pend_r || rstop_expire;
    src_bank  = `MSF_BANK_REAL;
    dst_bank  = `MSF_BANK_FEED;
    unique case (wmode_r)
      WM_REAL:    begin src_bank = `MSF_BANK_REAL; dst_bank = `MSF_BANK_FEED; end
      WM_SNAP:    begin src_bank = `MSF_BANK_FEED; dst_bank = `MSF_BANK_SNAP; end
      WM_RESTORE: begin src_bank = `MSF_BANK_SNAP; dst_bank = `MSF_BANK_FEED; end
      default:    begin src_bank = `MSF_BANK_REAL; dst_bank = `MSF_BANK_FEED; end
    endcase
    unique case (walk_r)
      W_IDLE: begin
        waxis_nxt = `MSF_FIRST_AXIS;
        if (fs_rise && positioning_active) begin
          walk_nxt  = W_READ;
          wmode_nxt = variant_new ? WM_REAL : WM_SNAP;
        end else if (restore_pend_nxt) begin
          walk_nxt  = W_READ;
          wmode_nxt = WM_RESTORE;
          restore_pend_nxt = 1'b0;
        end
      end
      W_READ: walk_nxt = W_WRITE;
      W_WRITE: begin
        waxis_nxt = waxis_r + `MSF_AXIS_STEP;
        if (waxis_r == `MSF_LAST_AXIS) begin
          walk_nxt  = W_IDLE;
          walk_done = 1'b1;
        end else begin
          walk_nxt = W_READ;
        end
      end
      default: walk_nxt = W_IDLE;
    endcase
    // The engine keeps writing feed values while the snapshot sits aside.
    eng_take  = axis_wr && axis_wr_ready;
    mem_re    = (walk_r == W_READ);
    mem_raddr = {src_bank, waxis_r};
    mem_we    = (walk_r == W_WRITE) || eng_take;
    mem_waddr = (walk_r == W_WRITE) ? {dst_bank, waxis_r} :
                {(axis_wr_real ? `MSF_BANK_REAL : `MSF_BANK_FEED), axis_wr_idx};
    mem_wdata = (walk_r == W_WRITE) ? mem_rdata : axis_wr_value;
    axis_ready_nxt = (walk_nxt == W_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      walk_r        <= W_IDLE;
      wmode_r       <= WM_REAL;
      waxis_r       <= `MSF_FIRST_AXIS;
      axis_wr_ready <= 1'b0;
      restore_pend_r <= 1'b0;
    end else begin
      walk_r        <= walk_nxt;
      wmode_r       <= wmode_nxt;
      waxis_r       <= waxis_nxt;
      axis_wr_ready <= axis_ready_nxt;
      restore_pend_r <= restore_pend_nxt;
    end
  end

  msf_axis_mem u_mem (
    .clk     (clk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .re      (mem_re),
    .raddr   (mem_raddr),
    .rdata_r (mem_rdata)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_READY_PASS: assert property ((rdy_r == RDY_CHECK && plc_ready_request &&
    !param_check_error) ##1 plc_ready_request |=> processor_ready_flag)
    else $error("Ready flag did not rise after a clean check.");
  AST_READY_FAIL: assert property (rdy_r == RDY_CHECK && param_check_error
    |=> !processor_ready_flag ##1 !processor_ready_flag)
    else $error("Ready flag rose despite a check error.");
  AST_XFER: assert property (servo_param_xfer && plc_ready_request
    |-> mcode_clear ##1 (processor_ready_flag && !servo_param_xfer))
    else $error("Parameter transfer and M-code clear out of step.");
  AST_READY_DROP: assert property (!plc_ready_request |=> !processor_ready_flag)
    else $error("Ready flag stayed up without the request.");
  AST_TEST_ERR: assert property (test_mode_request && !test_mode_allowed
    |=> test_request_error_flag)
    else $error("Refused test request left no error flag.");
  AST_REAL_LOAD: assert property (walk_r == W_WRITE && wmode_r == WM_REAL
    |-> mem_we && mem_waddr[`MSF_MEM_AW-1 -: `MSF_BANK_W] == `MSF_BANK_FEED)
    else $error("Real value not loaded into the feed bank.");
  AST_SERVO_OFF: assert property (forced_stop_input_flag && !$past(variant_new)
    |-> !all_axes_servo_on_cmd)
    else $error("Servo-on command held during a forced stop.");
  AST_RESTORE: assert property (rstop_expire
    |-> ##[1:40] (walk_r == W_READ && wmode_r == WM_RESTORE))
    else $error("Feed restore did not start when the time ran out.");
  AST_OVERSPEED: assert property (fs_fall && rstop_cnt_r != `MSF_RSTOP_RST
    |=> overspeed_error_flag)
    else $error("Early release raised no overspeed error.");
  AST_LATCH_SET: assert property ($rose(forced_stop_input_flag)
    |-> forced_stop_latch_flag)
    else $error("Stop latch missed a detected stop.");
  AST_LATCH_HOLD: assert property (forced_stop_latch_flag && !flags_wr
    |=> forced_stop_latch_flag)
    else $error("Stop latch cleared without a program write.");
  AST_OP_REFRESH: assert property (!op_tick |=> $stable(forced_stop_input_flag))
    else $error("Stop flag changed between operation ticks.");
  AST_MAIN_REFRESH: assert property (!main_tick
    |=> $stable(test_mode_on_flag) && $stable(scope_executing_flag))
    else $error("Main-cycle flag changed between main ticks.");

  COV_READY: cover property (rdy_r == RDY_XFER ##1 processor_ready_flag);
  COV_SNAP: cover property (wmode_r == WM_SNAP && walk_done);
  COV_RESTORE: cover property (wmode_r == WM_RESTORE && walk_done);
  COV_LATCH_CLR: cover property (forced_stop_latch_flag ##1 !forced_stop_latch_flag);

endmodule : msf_top

// ---- testbench/msf_amp_model.sv ----
`timescale 1ns/10ps
module msf_amp_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Commands from the controller.
  input  wire logic       servo_param_xfer,
  input  wire logic       all_axes_servo_on_cmd,
  // Amplifier state seen by the bench.
  output logic [7:0]      param_loads_r,
  output logic            servo_on_r
);
  // All amplifiers take the parameter set together, so one count stands for every axis.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      param_loads_r <= 8'h00;
      servo_on_r    <= 1'b0;
    end else begin
      if (servo_param_xfer) begin
        param_loads_r <= param_loads_r + 8'h01;
      end
      servo_on_r <= all_axes_servo_on_cmd;
    end
  end
endmodule : msf_amp_model

// ---- testbench/test_motion_status_flags.sv ----
`timescale 1ns/10ps
`include "msf_params.svh"
module test_motion_status_flags;
  logic        clk, rst_n, reg_wr, reg_rd, axis_wr, axis_wr_real, axis_wr_ready, irq;
  logic [3:0]  reg_addr;
  logic [2:0]  axis_wr_idx;
  logic [31:0] reg_wdata, reg_rdata, axis_wr_value, rd;
  logic        plc_ready_request, param_check_error, test_mode_request, test_mode_allowed;
  logic        test_mode_active, scope_active, forced_stop_input, positioning_active;
  logic        processor_ready_flag, test_mode_on_flag, forced_stop_input_flag;
  logic        scope_executing_flag, forced_stop_latch_flag, test_request_error_flag;
  logic        overspeed_error_flag, servo_param_xfer, mcode_clear, all_axes_servo_on_cmd;
  logic [7:0]  param_loads;
  logic        amp_servo_on;
  int          fail_count, n_checks, cyc_count, mcode_clears;

  // Short operation and main cycles keep the run brief.
  msf_top #(.OP_CYCLE_CYC(8), .MAIN_CYCLE_CYC(32)) uut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .plc_ready_request(plc_ready_request),
    .param_check_error(param_check_error), .test_mode_request(test_mode_request),
    .test_mode_allowed(test_mode_allowed), .test_mode_active(test_mode_active),
    .scope_active(scope_active), .forced_stop_input(forced_stop_input),
    .positioning_active(positioning_active), .axis_wr(axis_wr), .axis_wr_real(axis_wr_real),
    .axis_wr_idx(axis_wr_idx), .axis_wr_value(axis_wr_value), .axis_wr_ready(axis_wr_ready),
    .processor_ready_flag(processor_ready_flag), .test_mode_on_flag(test_mode_on_flag),
    .forced_stop_input_flag(forced_stop_input_flag), .scope_executing_flag(scope_executing_flag),
    .forced_stop_latch_flag(forced_stop_latch_flag), .overspeed_error_flag(overspeed_error_flag),
    .test_request_error_flag(test_request_error_flag), .servo_param_xfer(servo_param_xfer),
    .mcode_clear(mcode_clear), .all_axes_servo_on_cmd(all_axes_servo_on_cmd), .irq(irq));

  msf_amp_model amp (
    .clk(clk), .rst_n(rst_n), .servo_param_xfer(servo_param_xfer),
    .all_axes_servo_on_cmd(all_axes_servo_on_cmd), .param_loads_r(param_loads),
    .servo_on_r(amp_servo_on));

  always #4 clk = ~clk;

  task automatic print_verdict;
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // A hang anywhere ends the run as a failure rather than running forever.
  always @(posedge clk) begin
    if (mcode_clear) mcode_clears++;
    cyc_count++;
    if (cyc_count == 3000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe, so it is taken mid-cycle there.
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : reg_read

  task automatic wait_ready(input logic v);
    int k;
    k = 0;
    while (axis_wr_ready !== v && k < 40) begin
      @(negedge clk);
      k++;
    end
    cmp_bit(axis_wr_ready, v);
  endtask : wait_ready

  task automatic set_stop(input logic v);
    @(posedge clk);
    forced_stop_input <= v;
    cyc(11);
  endtask : set_stop

  initial begin
    clk = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 32'h0; axis_wr = 1'b0; axis_wr_real = 1'b0; axis_wr_idx = 3'h0;
    axis_wr_value = 32'h0; plc_ready_request = 1'b0; param_check_error = 1'b0;
    test_mode_request = 1'b0; test_mode_allowed = 1'b0; test_mode_active = 1'b0;
    scope_active = 1'b0; forced_stop_input = 1'b0; positioning_active = 1'b0;
    fail_count = 0; n_checks = 0; cyc_count = 0; mcode_clears = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(`MSF_REG_FLAGS, rd);
    cmp_word(rd, 32'h0);
    reg_read(4'h7, rd);
    cmp_word(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      axis_wr <= 1'b1; axis_wr_real <= i[0]; axis_wr_idx <= i[2:0]; axis_wr_value <= 32'h100 + i;
      @(posedge clk);
      axis_wr <= 1'b0;
    end
    @(posedge clk);
    param_check_error <= 1'b1;
    plc_ready_request <= 1'b1;
    cyc(5);
    cmp_bit(processor_ready_flag, 1'b0);
    cmp_word({24'h0, param_loads}, 32'h0);
    cmp_word(mcode_clears, 32'h0);
    @(posedge clk);
    plc_ready_request <= 1'b0;
    param_check_error <= 1'b0;
    cyc(2);
    @(posedge clk);
    plc_ready_request <= 1'b1;
    cyc(5);
    cmp_bit(processor_ready_flag, 1'b1);
    cmp_word({24'h0, param_loads}, 32'h1);
    cmp_word(mcode_clears, 32'h1);
    @(posedge clk);
    plc_ready_request <= 1'b0;
    cyc(3);
    cmp_bit(processor_ready_flag, 1'b0);
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk);
      test_mode_request <= 1'b1;
      test_mode_allowed <= i[0];
      @(posedge clk);
      test_mode_request <= 1'b0;
      cyc(1);
      cmp_bit(test_request_error_flag, ~i[0]);
    end
    reg_write(`MSF_REG_CTRL, 32'h1);
    reg_write(`MSF_REG_RSTOP, 32'h8);
    cyc(1);
    cmp_bit(all_axes_servo_on_cmd, 1'b1);
    @(posedge clk);
    test_mode_active <= 1'b1;
    scope_active <= 1'b1;
    positioning_active <= 1'b1;
    set_stop(1'b1);
    cmp_bit(forced_stop_input_flag, 1'b1);
    cmp_bit(forced_stop_latch_flag, 1'b1);
    cmp_bit(amp_servo_on, 1'b0);
    set_stop(1'b0);
    cmp_bit(forced_stop_input_flag, 1'b0);
    cmp_bit(forced_stop_latch_flag, 1'b1);
    cmp_bit(overspeed_error_flag, 1'b1);
    cyc(30);
    cmp_bit(test_mode_on_flag, 1'b1);
    cmp_bit(scope_executing_flag, 1'b1);
    reg_read(`MSF_REG_FLAGS, rd);
    cmp_word(rd, 32'h7a);
    reg_write(`MSF_REG_FLAGS, 32'h70);
    reg_read(`MSF_REG_FLAGS, rd);
    cmp_word(rd, 32'h0a);
    reg_write(`MSF_REG_RSTOP, 32'h2);
    reg_write(`MSF_REG_INT_STAT, 32'h1f);
    reg_write(`MSF_REG_INT_MASK, 32'h08);
    set_stop(1'b1);
    cmp_bit(all_axes_servo_on_cmd, 1'b0);
    cyc(30);
    cmp_bit(irq, 1'b1);
    reg_read(`MSF_REG_INT_STAT, rd);
    cmp_word(rd, 32'h0a);
    set_stop(1'b0);
    cmp_bit(all_axes_servo_on_cmd, 1'b1);
    reg_write(`MSF_REG_INT_STAT, 32'h1f);
    cyc(2);
    cmp_bit(irq, 1'b0);
    reg_write(`MSF_REG_CTRL, 32'h3);
    @(posedge clk);
    forced_stop_input <= 1'b1;
    wait_ready(1'b0);
    wait_ready(1'b1);
    cmp_bit(all_axes_servo_on_cmd, 1'b1);
    print_verdict();
  end
endmodule : test_motion_status_flags
